// ===== verilog/fpst_top.sv
/*
  Power-state and internal-operation timing of a small serial flash.
  Assumes cmd and out_ctl come from a decoder on clk; sclk_pin and
  select_low_n are raw pins and are synchronised here.
*/
`timescale 1ns/1ps
`include "fpst_defines.svh"

module fpst_top #(
  parameter int PP_CYC      = `FPST_CYC_MAX(`FPST_TPP_TYP_NS),
  parameter int PP_MAX_CYC  = `FPST_CYC_MAX(`FPST_TPP_MAX_NS),
  parameter int OTP_CYC     = `FPST_CYC_MAX(`FPST_TOTP_TYP_NS),
  parameter int OTP_MAX_CYC = `FPST_CYC_MAX(`FPST_TOTP_MAX_NS),
  parameter int CNT_W       = `FPST_CNT_W
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 sclk_pin,
  input  wire logic                 select_low_n,
  input  wire fpst_pkg::fpst_cmd_type cmd,
  input  wire fpst_pkg::fpst_out_type out_ctl,
  output logic                      so_o,
  output logic                      so_oe,
  output logic                      mode3,
  output fpst_pkg::fpst_status_type status
);
  import fpst_pkg::*;

  // power-down entry and resume absorb the pin edge latency to stay within limits; ultra-deep exit is a least time
  localparam int EDPD_CYC  = `FPST_CYC_MAX(`FPST_TEDPD_NS) - `FPST_EDGE_LAT;
  localparam int EUDPD_CYC = `FPST_CYC_MAX(`FPST_TEUDPD_NS) - `FPST_EDGE_LAT;
  localparam int RDPD_CYC  = `FPST_CYC_MAX(`FPST_TRDPD_NS) - `FPST_EDGE_LAT;
  localparam int XUDPD_CYC = `FPST_CYC_MIN(`FPST_TXUDPD_NS);
  localparam int WRSR_CYC  = `FPST_CYC_MAX(`FPST_TWRSR_NS);

  if (PP_CYC < 1 || PP_CYC > PP_MAX_CYC || OTP_CYC < 1 ||
      OTP_CYC > OTP_MAX_CYC || PP_MAX_CYC >= (1 << CNT_W) ||
      OTP_MAX_CYC >= (1 << CNT_W) || XUDPD_CYC >= (1 << CNT_W))
  begin : g_bad_param
    $error("fpst_top: busy counts do not fit their limits");
  end

  logic [1:0]          sync1_q;
  logic [1:0]          sync2_q;
  logic                cs_prev_q;
  logic                armed_q;
  logic                pend_q;
  fpst_cmd_kind_type   pend_kind_q;
  fpst_state_type      state_q;
  fpst_state_type      state_d;
  logic                so_oe_q;
  logic                so_q;
  logic                mode3_q;
  fpst_status_type     status_q;
  fpst_status_type     status_d;
  logic [CNT_W-1:0]    age_q;

  // bit 1 is the serial clock, bit 0 the select
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_q <= 2'h1;
      sync2_q <= 2'h1;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      sync1_q <= {sclk_pin, select_low_n};
      sync2_q <= sync1_q;
      cs_prev_q <= sync2_q[0];
    end
  end

  wire csn_s     = sync2_q[0];
  wire sclk_s    = sync2_q[1];
  wire cs_fall_w = cs_prev_q & ~csn_s;
  wire cs_rise_w = ~cs_prev_q & csn_s;

  wire len_ok_w  = (cmd.len != '0) &&
                   (cmd.len <= `FPST_LEN_W'(`FPST_PAGE_BYTES));
  wire kind_ok_w = (state_q == st_standby && cmd.kind != cmd_resume &&
                    (cmd.kind != cmd_page_prog || len_ok_w)) ||
                   (state_q == st_dpd && cmd.kind == cmd_resume);
  wire accept_w  = cmd.valid & armed_q & ~csn_s & kind_ok_w;
  wire start_w   = cs_rise_w & pend_q;
  wire done_w;

  always_ff @(posedge clk)
  begin
    if (rst)
      armed_q <= 1'b0;
    else if (cs_fall_w)
      armed_q <= 1'b1;
  end

  // a command taken in the fall cycle wins over the clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pend_q <= 1'b0;
      pend_kind_q <= cmd_deep_pd;
    end
    else if (accept_w)
    begin
      pend_q <= 1'b1;
      pend_kind_q <= cmd.kind;
    end
    else if (cs_fall_w || cs_rise_w)
      pend_q <= 1'b0;
  end

  wire fpst_state_type from_standby_w =
    (pend_kind_q == cmd_deep_pd)   ? st_enter_dpd  :
    (pend_kind_q == cmd_ultra_pd)  ? st_enter_udpd :
    (pend_kind_q == cmd_page_prog) ? st_prog       :
    (pend_kind_q == cmd_otp_prog)  ? st_otp        :
    (pend_kind_q == cmd_status_wr) ? st_wrsr       : st_standby;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      st_standby:
        if (start_w)
          state_d = from_standby_w;
      st_dpd:
        if (start_w && pend_kind_q == cmd_resume)
          state_d = st_resume;
      st_udpd:
        if (cs_fall_w)
          state_d = st_udpd_exit;
      st_enter_dpd:
        if (done_w)
          state_d = st_dpd;
      st_enter_udpd:
        if (done_w)
          state_d = st_udpd;
      st_resume, st_udpd_exit, st_prog, st_otp, st_wrsr:
        if (done_w)
          state_d = st_standby;
    endcase
  end

  wire timed_w = (state_d != state_q) && (state_d != st_standby) &&
                 (state_d != st_dpd) && (state_d != st_udpd);

  wire [CNT_W-1:0] load_val_w =
    (state_d == st_enter_dpd)  ? CNT_W'(EDPD_CYC)  :
    (state_d == st_enter_udpd) ? CNT_W'(EUDPD_CYC) :
    (state_d == st_resume)     ? CNT_W'(RDPD_CYC)  :
    (state_d == st_udpd_exit)  ? CNT_W'(XUDPD_CYC) :
    (state_d == st_prog)       ? CNT_W'(PP_CYC)    :
    (state_d == st_otp)        ? CNT_W'(OTP_CYC)   : CNT_W'(WRSR_CYC);

  fpst_busy_timer #(
    .CNT_W    (CNT_W)
  ) u_timer (
    .clk      (clk),
    .rst      (rst),
    .load     (timed_w),
    .load_val (load_val_w),
    .done     (done_w)
  );

  assign status_d.standby  = (state_d == st_standby);
  assign status_d.deep_pd  = (state_d == st_dpd);
  assign status_d.ultra_pd = (state_d == st_udpd);
  assign status_d.busy     = timed_w || ((state_d == state_q) &&
                             !status_d.standby && !status_d.deep_pd &&
                             !status_d.ultra_pd);
  assign status_d.armed    = armed_q | cs_fall_w;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= st_standby;
      status_q <= '{standby: 1'b1, default: 1'b0};
      age_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      status_q <= status_d;
      age_q <= (state_d != state_q) ? '0 :
               (age_q != '1) ? age_q + CNT_W'(1) : age_q;
    end
  end

  // output driven only on request in a frame
  always_ff @(posedge clk)
  begin
    if (rst || cs_rise_w)
      so_oe_q <= 1'b0;
    else if (out_ctl.want && armed_q && !csn_s && state_q == st_standby)
      so_oe_q <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      so_q <= 1'b0;
    else if (out_ctl.want)
      so_q <= out_ctl.bit_val;
  end

  // idle clock level at select fall
  always_ff @(posedge clk)
  begin
    if (rst)
      mode3_q <= 1'b0;
    else if (cs_fall_w)
      mode3_q <= sclk_s;
  end

  assign so_o   = so_q;
  assign so_oe  = so_oe_q;
  assign mode3  = mode3_q;
  assign status = status_q;

  sequence s_start(fpst_state_type from, fpst_cmd_kind_type k);
    state_q == from && start_w && pend_kind_q == k;
  endsequence

  sequence s_wake;
    state_q == st_udpd ##0 cs_fall_w;
  endsequence

  a_dpd_entry: assert property (@(posedge clk) disable iff (rst)
    s_start(st_standby, cmd_deep_pd) |=> ##[1:EDPD_CYC] status_q.deep_pd)
    else $error("deep power-down entered late");
  a_udpd_entry: assert property (@(posedge clk) disable iff (rst)
    s_start(st_standby, cmd_ultra_pd) |=> ##[1:EUDPD_CYC] status_q.ultra_pd)
    else $error("ultra-deep power-down entered late");
  a_resume_time: assert property (@(posedge clk) disable iff (rst)
    s_start(st_dpd, cmd_resume) |=> status_q.busy ##[1:RDPD_CYC]
    status_q.standby)
    else $error("resume to standby too slow");
  a_prog_max: assert property (@(posedge clk) disable iff (rst)
    state_q == st_prog |-> age_q < CNT_W'(PP_MAX_CYC))
    else $error("page program exceeds maximum");
  a_otp_max: assert property (@(posedge clk) disable iff (rst)
    state_q == st_otp |-> age_q < CNT_W'(OTP_MAX_CYC))
    else $error("security area program exceeds maximum");
  a_wrsr_time: assert property (@(posedge clk) disable iff (rst)
    s_start(st_standby, cmd_status_wr) |=> ##[1:WRSR_CYC] status_q.standby)
    else $error("status write exceeds maximum");
  a_udpd_wake: assert property (@(posedge clk) disable iff (rst)
    s_wake |=> state_q == st_udpd_exit && status_q.busy)
    else $error("ultra-deep wake missed");
  a_udpd_recover: assert property (@(posedge clk) disable iff (rst)
    state_q == st_udpd_exit |-> age_q < CNT_W'(XUDPD_CYC))
    else $error("ultra-deep recovery overruns");
  a_so_hiz: assert property (@(posedge clk) disable iff (rst)
    $rose(so_oe) |-> $past(out_ctl.want && armed_q && !csn_s))
    else $error("serial output driven without request");
  a_no_arm_idle: assert property (@(posedge clk) disable iff (rst)
    (state_q == st_standby && !armed_q) |=> state_q == st_standby)
    else $error("instruction taken before select fall");
  a_mode_sample: assert property (@(posedge clk) disable iff (rst)
    cs_fall_w |=> mode3 == $past(sclk_s))
    else $error("spi mode not sampled at select fall");

endmodule // fpst_top

// ===== verilog/fpst_defines.svh
/*
  Timing figures and field widths for the flash power-state sequencer.
  Assumes the includer uses them only through the macros below.
*/
`ifndef FPST_DEFINES_SVH
`define FPST_DEFINES_SVH

`define FPST_CLK_NS        40
`define FPST_TEDPD_NS      3000
`define FPST_TEUDPD_NS     3000
`define FPST_TRDPD_NS      8000
`define FPST_TXUDPD_NS     70000
`define FPST_TCSLU_NS      20
`define FPST_TPP_TYP_NS    2000000
`define FPST_TPP_MAX_NS    5000000
`define FPST_TOTP_TYP_NS   400000
`define FPST_TOTP_MAX_NS   950000
`define FPST_TWRSR_NS      200
`define FPST_PAGE_BYTES    256
`define FPST_LEN_W         9
`define FPST_CNT_W         17
// pin edge to state change: two sync flops and the edge compare
`define FPST_EDGE_LAT      3

// longest time: round down, never below one cycle
`define FPST_CYC_MAX(t) (((t) / `FPST_CLK_NS) < 1 ? 1 : ((t) / `FPST_CLK_NS))
// least time: round up
`define FPST_CYC_MIN(t) (((t) + `FPST_CLK_NS - 1) / `FPST_CLK_NS)

`endif

// ===== verilog/fpst_pkg.sv
/*
  Types shared by the flash power-state sequencer.
  Assumes fpst_defines.svh is on the include path.
*/
`include "fpst_defines.svh"

package fpst_pkg;

  typedef enum logic [2:0] {
    cmd_deep_pd,
    cmd_ultra_pd,
    cmd_resume,
    cmd_page_prog,
    cmd_otp_prog,
    cmd_status_wr
  } fpst_cmd_kind_type;

  typedef struct packed {
    logic                     valid;
    fpst_cmd_kind_type        kind;
    logic [`FPST_LEN_W-1:0]   len;
  } fpst_cmd_type;

  typedef struct packed {
    logic want;
    logic bit_val;
  } fpst_out_type;

  typedef struct packed {
    logic standby;
    logic deep_pd;
    logic ultra_pd;
    logic busy;
    logic armed;
  } fpst_status_type;

  typedef enum logic [3:0] {
    st_standby,
    st_enter_dpd,
    st_dpd,
    st_resume,
    st_enter_udpd,
    st_udpd,
    st_udpd_exit,
    st_prog,
    st_otp,
    st_wrsr
  } fpst_state_type;

endpackage

// ===== verilog/fpst_busy_timer.sv
/*
  Down-counter that times one internal operation or power transition.
  Assumes load is a single-cycle pulse on the same clock.
*/
`timescale 1ns/1ps

module fpst_busy_timer #(
  parameter int CNT_W = 17
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_q;

  if (CNT_W < 2)
  begin : g_bad_width
    $error("fpst_busy_timer: CNT_W too small");
  end

  // done rises in the cycle the count reaches one
  assign done = (cnt_q == CNT_W'(1));

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (load)
      cnt_q <= load_val;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - CNT_W'(1);
  end

endmodule // fpst_busy_timer

// ===== bench/fpst_host_model.sv
/*
  Host-side model: drives select and the serial clock of the flash.
  Assumes the bench calls its tasks just after a clk edge.
*/
`timescale 1ns/1ps

module fpst_host_model #(
  parameter int PUW_NS = 3000000
) (
  output logic sclk_pin,
  output logic select_low_n
);
  logic run  = 1'b0;
  logic idle = 1'b0;

  initial sclk_pin = 1'b0;
  initial select_low_n = 1'b1;

  // link clock only runs inside a frame
  always #160 if (run) sclk_pin = ~sclk_pin;

  // clock parked at its idle level
  task automatic open_frame(input logic m3);
    #3 idle = m3;
    sclk_pin = m3;
    #100 select_low_n = 1'b0;
    #120 run = 1'b1;
  endtask

  task automatic close_frame();
    #3 run = 1'b0;
    #200 sclk_pin = idle;
    #3 select_low_n = 1'b1;
  endtask

  task automatic wake_ultra();
    #3 select_low_n = 1'b0;
    #80 select_low_n = 1'b1;
    #70000;
  endtask

  task automatic wait_powerup();
    if ($time < PUW_NS) #(PUW_NS - $time);
  endtask
endmodule // fpst_host_model

// ===== bench/tb_flash_power_state_timing.sv
/*
  Self-checking bench for the flash power-state sequencer.
  Assumes design files and the host model are compiled before it.
*/
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      err_total++; \
      $display("unexpected at %0t: got %0h exp %0h", $time, a, b); \
    end \
  end

module tb_flash_power_state_timing;
  import fpst_pkg::*;
  logic            clk;
  logic            rst;
  logic            sclk_pin;
  logic            select_low_n;
  fpst_cmd_type    cmd;
  fpst_out_type    out_ctl;
  logic            so_o;
  logic            so_oe;
  logic            mode3;
  fpst_status_type status;
  fpst_status_type e_st;
  fpst_status_type exp_st_q[$];
  int              exp_n_q[$];
  int              e_n;
  int              bcnt = 0;
  int              err_total = 0;
  int              n_tests = 0;
  logic [31:0]     seed = 32'hF72F;

  fpst_top #(.PP_CYC(40), .OTP_CYC(20))
  fpst_top_i (.clk(clk), .rst(rst), .sclk_pin(sclk_pin),
    .select_low_n(select_low_n), .cmd(cmd), .out_ctl(out_ctl),
    .so_o(so_o), .so_oe(so_oe), .mode3(mode3), .status(status));

  fpst_host_model #(.PUW_NS(4000))
  fpst_host_model_i (.sclk_pin(sclk_pin), .select_low_n(select_low_n));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one framed command; tgt is {standby, deep, ultra}, n = 0 if refused
  task automatic op(input fpst_cmd_kind_type k, input logic [8:0] len,
                    input logic m3, input logic [2:0] tgt, input int n);
    int i;
    if (n > 0)
    begin
      exp_st_q.push_back('{standby: tgt[2], deep_pd: tgt[1],
        ultra_pd: tgt[0], busy: 1'b0, armed: 1'b1});
      exp_n_q.push_back(n);
    end
    fpst_host_model_i.open_frame(m3);
    cyc(8);
    @(negedge clk);
    `CHK(mode3, m3)
    @(posedge clk);
    cmd <= '{valid: 1'b1, kind: k, len: len};
    cyc(1);
    cmd.valid <= 1'b0;
    fpst_host_model_i.close_frame();
    for (i = 0; i < 3000 && exp_n_q.size() != 0; i++)
      @(posedge clk);
    cyc(8);
    @(negedge clk);
    `CHK(status.busy, 1'b0)
    $display("test %s done", k.name());
  endtask

  // busy end: compare end state and busy length with oldest note
  always @(negedge clk)
  begin
    if (rst)
      bcnt = 0;
    else if (status.busy === 1'b1)
      bcnt++;
    else if (bcnt != 0)
    begin
      if (exp_n_q.size() == 0)
      begin
        err_total++;
        $display("unexpected at %0t: busy without request", $time);
      end
      else
      begin
        e_st = exp_st_q.pop_front();
        e_n = exp_n_q.pop_front();
        `CHK(status, e_st)
        `CHK(bcnt, e_n)
      end
      bcnt = 0;
    end
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    rst = 1'b1;
    cmd = '0;
    out_ctl = '0;
    cyc(5);
    rst <= 1'b0;
    cyc(2);
    out_ctl <= '{want: 1'b1, bit_val: 1'b1};
    cyc(1);
    out_ctl.want <= 1'b0;
    @(negedge clk);
    `CHK(so_oe, 1'b0)
    `CHK(status.armed, 1'b0)
    fpst_host_model_i.wait_powerup();
    fpst_host_model_i.open_frame(1'b0);
    cyc(8);
    seed = lfsr(seed);
    out_ctl <= '{want: 1'b1, bit_val: seed[0]};
    cyc(3);
    @(negedge clk);
    `CHK(so_oe, 1'b1)
    `CHK(so_o, seed[0])
    @(posedge clk);
    rst <= 1'b1;
    out_ctl.want <= 1'b0;
    cyc(2);
    @(negedge clk);
    `CHK(so_oe, 1'b0)
    fpst_host_model_i.close_frame();
    cyc(5);
    rst <= 1'b0;
    cyc(4);
    @(negedge clk);
    `CHK(status.armed, 1'b0)
    $display("test reset_state done");
    seed = lfsr(seed);
    op(cmd_status_wr, 9'h000, 1'b1, 3'b100, 5);
    op(cmd_page_prog, {1'b0, seed[7:0]} + 9'h001, 1'b0, 3'b100, 40);
    op(cmd_page_prog, 9'h100, 1'b1, 3'b100, 40);
    op(cmd_page_prog, 9'h000, 1'b0, 3'b100, 0);
    op(cmd_resume, 9'h000, 1'b1, 3'b100, 0);
    op(cmd_otp_prog, 9'h000, 1'b0, 3'b100, 20);
    op(cmd_deep_pd, 9'h000, 1'b1, 3'b010, 72);
    op(cmd_resume, 9'h000, 1'b0, 3'b100, 197);
    op(cmd_ultra_pd, 9'h000, 1'b1, 3'b001, 72);
    exp_st_q.push_back('{standby: 1'b1, deep_pd: 1'b0, ultra_pd: 1'b0,
      busy: 1'b0, armed: 1'b1});
    exp_n_q.push_back(1750);
    fpst_host_model_i.wake_ultra();
    cyc(2);
    `CHK(exp_n_q.size(), 0)
    $display("test wake done");
    op(cmd_status_wr, 9'h000, 1'b0, 3'b100, 5);
    tally_and_finish();
  end
endmodule // tb_flash_power_state_timing
